// >>> chan_pwr_defines.vh
`ifndef CHAN_PWR_DEFINES_VH
`define CHAN_PWR_DEFINES_VH

// Register port geometry
`define REG_ADDR_W          6
`define REG_DATA_W          16

// Register offsets
`define ADDR_CHAN_INT_DIV   6'h0f
`define ADDR_CHAN_FRAC_NUM  6'h10
`define ADDR_TX_AMP_LEVEL   6'h12

// Reset values
`define RST_CHAN_INT_DIV    16'h0095
`define RST_CHAN_FRAC_NUM   16'h5000
`define RST_TX_AMP_LEVEL    16'h00bc

// Writable bit masks; zero bits hold their reset value
`define WMASK_LOW_BYTE      16'h00ff
`define WMASK_ALL           16'hffff

// Field positions
`define DIV_MSB             7
`define DIV_LSB             0
`define PWR_COARSE_MSB      7
`define PWR_COARSE_LSB      6
`define PWR_FINE_MSB        5
`define PWR_FINE_LSB        4
`define DRV_COARSE_MSB      3
`define DRV_COARSE_LSB      2
`define DRV_FINE_MSB        1
`define DRV_FINE_LSB        0

// Answer to a read of an unmapped offset
`define RDATA_UNMAPPED      16'h0000

`endif

// >>> masked_reg16.v
`timescale 1ns/1ps
`default_nettype none

`include "chan_pwr_defines.vh"

module masked_reg16 #(
	parameter [15:0] RESET_VAL = 16'h0000,
	parameter [15:0] WR_MASK   = 16'hffff
) (
	input  wire        sys_clk_in,
	input  wire        arst_n_in,
	input  wire        wr_en_in,
	input  wire [15:0] wdata_in,
	output wire [15:0] q_out
);

	reg [15:0] value_ff;

	// Unmasked bits take only the reset constant, so they can never drift
	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_bit
			if (WR_MASK[i]) begin : g_rw
				always @(posedge sys_clk_in or negedge arst_n_in) begin
					if (!arst_n_in) begin
						value_ff[i] <= RESET_VAL[i];
					end else if (wr_en_in) begin
						value_ff[i] <= wdata_in[i];
					end
				end
			end else begin : g_fixed
				always @(posedge sys_clk_in or negedge arst_n_in) begin
					if (!arst_n_in) begin
						value_ff[i] <= RESET_VAL[i];
					end else begin
						value_ff[i] <= RESET_VAL[i];
					end
				end
			end
		end
	endgenerate

	assign q_out = value_ff;

endmodule

`default_nettype wire

// >>> channel_and_tx_power_regs.v
`timescale 1ns/1ps
`default_nettype none

`include "chan_pwr_defines.vh"

module channel_and_tx_power_regs (
	input  wire                   sys_clk_in,
	input  wire                   arst_n_in,
	input  wire [`REG_ADDR_W-1:0] reg_addr_in,
	input  wire                   reg_wr_en_in,
	input  wire                   reg_rd_en_in,
	input  wire [`REG_DATA_W-1:0] reg_wdata_in,
	output reg  [`REG_DATA_W-1:0] reg_rdata_out,
	output reg                    reg_rd_valid_out,
	output reg                    reg_addr_hit_out,
	output reg  [7:0]             synth_integer_divisor_out,
	output reg  [15:0]            synth_fraction_numerator_out,
	output reg                    channel_update_out,
	output reg  [1:0]             amp_power_coarse_out,
	output reg  [1:0]             amp_power_fine_out,
	output reg  [1:0]             amp_drive_coarse_out,
	output reg  [1:0]             amp_drive_fine_out
);

	wire                   sel_div;
	wire                   sel_num;
	wire                   sel_amp;
	wire                   wr_div;
	wire                   wr_num;
	wire                   wr_amp;
	wire [`REG_DATA_W-1:0] div_q;
	wire [`REG_DATA_W-1:0] num_q;
	wire [`REG_DATA_W-1:0] amp_q;
	reg  [`REG_DATA_W-1:0] nxt_rdata;
	reg                    nxt_hit;
	reg                    chan_written_ff;

	assign sel_div = (reg_addr_in == `ADDR_CHAN_INT_DIV);
	assign sel_num = (reg_addr_in == `ADDR_CHAN_FRAC_NUM);
	assign sel_amp = (reg_addr_in == `ADDR_TX_AMP_LEVEL);
	assign wr_div  = reg_wr_en_in & sel_div;
	assign wr_num  = reg_wr_en_in & sel_num;
	assign wr_amp  = reg_wr_en_in & sel_amp;

	masked_reg16 #(
		.RESET_VAL (`RST_CHAN_INT_DIV),
		.WR_MASK   (`WMASK_LOW_BYTE)
	) u_div_reg (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.wr_en_in   (wr_div),
		.wdata_in   (reg_wdata_in),
		.q_out      (div_q)
	);

	masked_reg16 #(
		.RESET_VAL (`RST_CHAN_FRAC_NUM),
		.WR_MASK   (`WMASK_ALL)
	) u_num_reg (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.wr_en_in   (wr_num),
		.wdata_in   (reg_wdata_in),
		.q_out      (num_q)
	);

	masked_reg16 #(
		.RESET_VAL (`RST_TX_AMP_LEVEL),
		.WR_MASK   (`WMASK_LOW_BYTE)
	) u_amp_reg (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.wr_en_in   (wr_amp),
		.wdata_in   (reg_wdata_in),
		.q_out      (amp_q)
	);

	// Read mux; a write and read in the same cycle returns the old value
	always @* begin
		nxt_rdata = `RDATA_UNMAPPED;
		nxt_hit   = 1'b1;
		case (reg_addr_in)
			`ADDR_CHAN_INT_DIV: begin
				nxt_rdata = div_q;
			end
			`ADDR_CHAN_FRAC_NUM: begin
				nxt_rdata = num_q;
			end
			`ADDR_TX_AMP_LEVEL: begin
				nxt_rdata = amp_q;
			end
			default: begin
				nxt_rdata = `RDATA_UNMAPPED;
				nxt_hit   = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out    <= `RDATA_UNMAPPED;
			reg_rd_valid_out <= 1'b0;
			reg_addr_hit_out <= 1'b0;
		end else begin
			reg_rd_valid_out <= reg_rd_en_in;
			reg_addr_hit_out <= (reg_rd_en_in | reg_wr_en_in) & nxt_hit;
			if (reg_rd_en_in) begin
				reg_rdata_out <= nxt_rdata;
			end
		end
	end

	// Field reset images, cut from the full register reset words, so a reset
	// shows the same settings that the storage holds after the first edge
	localparam [15:0] DIV_RST_WORD   = `RST_CHAN_INT_DIV;
	localparam [15:0] AMP_RST_WORD   = `RST_TX_AMP_LEVEL;
	localparam [7:0]  DIV_RST        = DIV_RST_WORD[`DIV_MSB:`DIV_LSB];
	localparam [1:0]  PWR_COARSE_RST = AMP_RST_WORD[`PWR_COARSE_MSB:`PWR_COARSE_LSB];
	localparam [1:0]  PWR_FINE_RST   = AMP_RST_WORD[`PWR_FINE_MSB:`PWR_FINE_LSB];
	localparam [1:0]  DRV_COARSE_RST = AMP_RST_WORD[`DRV_COARSE_MSB:`DRV_COARSE_LSB];
	localparam [1:0]  DRV_FINE_RST   = AMP_RST_WORD[`DRV_FINE_MSB:`DRV_FINE_LSB];

	// Field slices of the stored words; the layout fixes them
	wire [7:0]             div_field;
	wire [1:0]             pwr_coarse_field;
	wire [1:0]             pwr_fine_field;
	wire [1:0]             drv_coarse_field;
	wire [1:0]             drv_fine_field;

	assign div_field        = div_q[`DIV_MSB:`DIV_LSB];
	assign pwr_coarse_field = amp_q[`PWR_COARSE_MSB:`PWR_COARSE_LSB];
	assign pwr_fine_field   = amp_q[`PWR_FINE_MSB:`PWR_FINE_LSB];
	assign drv_coarse_field = amp_q[`DRV_COARSE_MSB:`DRV_COARSE_LSB];
	assign drv_fine_field   = amp_q[`DRV_FINE_MSB:`DRV_FINE_LSB];

	// Outputs are one more flop behind the storage so every top output is registered;
	// the analog side sees a new setting one edge after the write edge
	// divisor to oscillator
	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			synth_integer_divisor_out <= DIV_RST;
		end else begin
			synth_integer_divisor_out <= div_field;
		end
	end

	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			synth_fraction_numerator_out <= `RST_CHAN_FRAC_NUM;
		end else begin
			synth_fraction_numerator_out <= num_q;
		end
	end

	// Power and drive share one stored word but leave as separate ports
	// coarse power level
	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			amp_power_coarse_out <= PWR_COARSE_RST;
		end else begin
			amp_power_coarse_out <= pwr_coarse_field;
		end
	end

	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			amp_power_fine_out <= PWR_FINE_RST;
		end else begin
			amp_power_fine_out <= pwr_fine_field;
		end
	end

	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			amp_drive_coarse_out <= DRV_COARSE_RST;
		end else begin
			amp_drive_coarse_out <= drv_coarse_field;
		end
	end

	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			amp_drive_fine_out <= DRV_FINE_RST;
		end else begin
			amp_drive_fine_out <= drv_fine_field;
		end
	end

	// channel pair update
	// Pulse marks a written channel word so the synthesizer can relock; software
	// writing divisor then numerator gets two pulses, or one two-cycle pulse if back to back, the last cycle with the full pair
	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chan_written_ff    <= 1'b0;
			channel_update_out <= 1'b0;
		end else begin
			chan_written_ff    <= wr_div | wr_num;
			channel_update_out <= chan_written_ff;
		end
	end

endmodule

`default_nettype wire

// >>> chan_pwr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module chan_pwr_monitor (
	input wire logic        sys_clk_in, arst_n_in, reg_wr_en_in, reg_rd_en_in,
	input wire logic [5:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in, reg_rdata_out, synth_fraction_numerator_out,
	input wire logic        reg_rd_valid_out, reg_addr_hit_out, channel_update_out,
	input wire logic [7:0]  synth_integer_divisor_out,
	input wire logic [1:0]  amp_power_coarse_out, amp_power_fine_out,
	input wire logic [1:0]  amp_drive_coarse_out, amp_drive_fine_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);
	wire wdiv = reg_wr_en_in && reg_addr_in == 6'h0f;
	wire wnum = reg_wr_en_in && reg_addr_in == 6'h10;
	wire wamp = reg_wr_en_in && reg_addr_in == 6'h12;
	wire [15:0] div = {8'h00, synth_integer_divisor_out};
	wire [15:0] amp = {8'h00, amp_power_coarse_out, amp_power_fine_out,
		amp_drive_coarse_out, amp_drive_fine_out};
	a_read_valid: assert property (reg_rd_en_in |=> reg_rd_valid_out)
		else $error("read valid missing");
	a_valid_asked: assert property (!reg_rd_en_in |=> !reg_rd_valid_out)
		else $error("read valid unasked");
	a_div_write: assert property (wdiv |=> ##1 div == ($past(reg_wdata_in, 2) & 16'h00ff))
		else $error("divisor not applied");
	a_num_write: assert property (wnum |=> ##1 synth_fraction_numerator_out == $past(reg_wdata_in, 2))
		else $error("numerator not applied");
	a_amp_write: assert property (wamp |=> ##1 amp == ($past(reg_wdata_in, 2) & 16'h00ff))
		else $error("amp fields not applied");
	a_div_held: assert property ($changed(div) |-> $past(wdiv, 2))
		else $error("divisor changed unasked");
	a_upper_zero: assert property (reg_rd_en_in && reg_addr_in != 6'h10 |=> reg_rdata_out[15:8] == 8'h00)
		else $error("reserved bits not zero");
	a_unmapped_miss: assert property (reg_rd_en_in && !(reg_addr_in inside {6'h0f, 6'h10, 6'h12}) |=> !reg_addr_hit_out)
		else $error("unmapped offset hit");
	a_mapped_hit: assert property ((reg_rd_en_in || reg_wr_en_in) && (reg_addr_in inside {6'h0f, 6'h10, 6'h12}) |=> reg_addr_hit_out)
		else $error("mapped offset missed");
	a_update_pulse: assert property ((wdiv || wnum) |=> ##1 channel_update_out)
		else $error("channel update missing");
	a_update_asked: assert property (channel_update_out |-> $past(wdiv, 2) || $past(wnum, 2))
		else $error("channel update unasked");
endmodule
`default_nettype wire

// >>> channel_and_tx_power_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module channel_and_tx_power_regs_bench;
	logic sys_clk_in = 0, arst_n_in = 0, reg_wr_en_in = 0, reg_rd_en_in = 0;
	logic [5:0] reg_addr_in = 6'h00;
	logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, synth_fraction_numerator_out, xn;
	logic reg_rd_valid_out, reg_addr_hit_out, channel_update_out;
	logic [7:0] synth_integer_divisor_out, xd, xa;
	logic [1:0] amp_power_coarse_out, amp_power_fine_out, amp_drive_coarse_out, amp_drive_fine_out;
	logic [15:0] q[$];
	logic [23:0] chan[3] = '{24'h95_f000, 24'h96_4000, 24'h9a_0000};
	int n_errors = 0, checks_done = 0;
	channel_and_tx_power_regs dut (.*);
	initial forever #12.5 sys_clk_in = ~sys_clk_in;
	task chk(string n, logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// For a read, d is the expected answer
	task acc(logic w, logic [5:0] a, logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_en_in <= w;
		reg_rd_en_in <= !w;
		if (!w) q.push_back(d);
		@(posedge sys_clk_in);
		reg_wr_en_in <= 1'b0;
		reg_rd_en_in <= 1'b0;
	endtask
	task fld(int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
		chk("fields", {xd, xn, xa}, {synth_integer_divisor_out, synth_fraction_numerator_out,
			amp_power_coarse_out, amp_power_fine_out, amp_drive_coarse_out, amp_drive_fine_out});
	endtask
	always @(posedge sys_clk_in) begin
		if (reg_rd_valid_out === 1'b1) begin
			if (q.size() > 0) begin
				chk("rdata", q.pop_front(), reg_rdata_out);
			end else begin
				chk("rd_valid", 32'h0000_0000, reg_rd_valid_out);
			end
		end
	end
	task stop_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		xd = 8'h95;
		xn = 16'h5000;
		xa = 8'hbc;
		void'($urandom(25756));
		repeat (5) @(posedge sys_clk_in);
		arst_n_in <= 1'b1;
		fld(0);
		fld(2);
		acc(0, 6'h0f, 16'h0095);
		acc(0, 6'h10, 16'h5000);
		acc(0, 6'h12, 16'h00bc);
		acc(0, 6'h11, 16'h0000);
		$display("test reset done");
		foreach (chan[i]) begin
			xd = chan[i][23:16];
			xn = chan[i][15:0];
			// Upper byte is junk on purpose
			acc(1, 6'h0f, {8'($urandom), xd});
			acc(1, 6'h10, xn);
			fld(2);
			acc(0, 6'h0f, {8'h00, xd});
			acc(0, 6'h10, xn);
		end
		$display("test channel done");
		repeat (4) begin
			// Drive fields stay at their reset setting; only power is swept
			xa = {4'($urandom), 4'hc};
			acc(1, 6'h12, {8'($urandom), xa});
			acc(1, 6'h11, 16'($urandom));
			fld(2);
			acc(0, 6'h12, {8'h00, xa});
		end
		$display("test amp done");
		repeat (3) @(posedge sys_clk_in);
		chk("pending reads", 32'h0000_0000, q.size());
		stop_test;
	end
	initial begin
		#50000;
		n_errors++;
		stop_test;
	end
endmodule
bind channel_and_tx_power_regs chan_pwr_monitor mon (.*);
`default_nettype wire
